// >>> rtl/fctim_pkg.sv
`default_nettype none
package fctim_pkg;
    // Source clock select codes
    localparam logic [2:0] SRC_4096HZ = 3'h0;
    localparam logic [2:0] SRC_64HZ = 3'h1;
    localparam logic [2:0] SRC_1HZ = 3'h2;
    localparam logic [2:0] SRC_MIN = 3'h3;
    localparam logic [2:0] SRC_HOUR = 3'h4;
    // Clock rate
    localparam int FCLK_KHZ = 25000;
    // Base tick period, 4096 Hz, in ns
    localparam int TICK_PERIOD_NS = 244140;
    // Scaled through MHz so the product stays inside 32 bits
    localparam int TICK_CYCLES = TICK_PERIOD_NS * (FCLK_KHZ / 1000) / 1000;
    // Ratios of the cascaded source clocks
    localparam int DIV_4096_TO_64 = 64;
    localparam int DIV_64_TO_1 = 64;
    localparam int DIV_1_TO_MIN = 60;
    localparam int DIV_MIN_TO_HOUR = 60;
    // Auto release time of an asserted interrupt
    localparam int REL_FAST_NS = 122000;
    localparam int REL_SLOW_NS = 7813000;
    localparam int REL_FAST_CYCLES = REL_FAST_NS * (FCLK_KHZ / 1000) / 1000;
    localparam int REL_SLOW_CYCLES = REL_SLOW_NS / 1000 * FCLK_KHZ / 1000;
    // Widths and reset values
    localparam int COUNT_W = 16;
    localparam int REL_W = 24;
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
endpackage
`default_nettype wire

// >>> rtl/fctim_tick_if.sv
`default_nettype none
interface fctim_tick_if;
    // One-cycle enables: 4096 Hz, 64 Hz, 1 Hz, 1/60 Hz, 1/3600 Hz
    logic [4:0] tick;
    modport src (output tick);
    modport snk (input tick);
endinterface
`default_nettype wire

// >>> rtl/fctim_prescaler.sv
`default_nettype none
module fctim_prescaler #(
    parameter int TICK_CYCLES = fctim_pkg::TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    fctim_tick_if.src tk
);
    import fctim_pkg::*;

    localparam int DIVS [4] = '{DIV_4096_TO_64, DIV_64_TO_1, DIV_1_TO_MIN, DIV_MIN_TO_HOUR};

    logic [23:0] base_cnt;
    logic [4:0] tick;

    // ====================================
    // Base 4096 Hz enable
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            base_cnt <= 24'h000000;
            tick[0] <= 1'b0;
        end
        else if (base_cnt == 24'(TICK_CYCLES - 1))
        begin
            base_cnt <= 24'h000000;
            tick[0] <= 1'b1;
        end
        else
        begin
            base_cnt <= base_cnt + 24'h000001;
            tick[0] <= 1'b0;
        end
    end

    // ====================================
    // Cascaded slower enables
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_stage
            logic [6:0] cnt;
            always_ff @(posedge i_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    cnt <= 7'h00;
                    tick[g+1] <= 1'b0;
                end
                else if (tick[g] && cnt == 7'(DIVS[g] - 1))
                begin
                    cnt <= 7'h00;
                    tick[g+1] <= 1'b1;
                end
                else
                begin
                    if (tick[g])
                    begin
                        cnt <= cnt + 7'h01;
                    end
                    tick[g+1] <= 1'b0;
                end
            end
        end
    endgenerate

    assign tk.tick = tick;
endmodule
`default_nettype wire

// >>> rtl/fctim_top.sv
`default_nettype none
module fctim_top #(
    parameter int TICK_CYCLES = fctim_pkg::TICK_CYCLES,
    parameter int REL_SLOW_CYCLES = fctim_pkg::REL_SLOW_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ser_clk,
    input wire logic i_count_run,
    input wire logic [fctim_pkg::COUNT_W-1:0] i_preset,
    input wire logic i_source_clock_select_hi,
    input wire logic i_source_clock_select_mid,
    input wire logic i_source_clock_select_lo,
    input wire logic i_timer_irq_enable,
    input wire logic i_supply_gating_enable,
    input wire logic i_backup_only_select,
    input wire logic i_on_backup,
    input wire logic i_count_hold,
    input wire logic i_clock_halt,
    input wire logic i_irq_route_select,
    input wire logic i_flag_clear,
    output logic o_timer_event_flag,
    output logic o_running,
    output logic [fctim_pkg::COUNT_W-1:0] o_count,
    output logic o_int_out_a,
    output logic o_int_out_a_oe,
    output logic o_int_out_b,
    output logic o_int_out_b_oe
);
    import fctim_pkg::*;

    fctim_tick_if tk ();
    logic [2:0] sel;
    logic sel_tick;
    logic supply_ok;
    logic hold_eff;
    logic halt_stop;
    logic advance;
    logic event_now;
    logic ser_s1, ser_s2, ser_s3, ser_lvl;
    logic ser_rise;
    logic run_prev;
    logic start_pending;
    logic [COUNT_W-1:0] count;
    logic [REL_W-1:0] rel_cnt;
    logic [REL_W-1:0] rel_limit;
    logic irq_active;

    fctim_prescaler #(.TICK_CYCLES(TICK_CYCLES)) u_prescaler (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .tk(tk.src)
    );

    // ====================================
    // Source clock selection and gating
    assign sel = {i_source_clock_select_hi, i_source_clock_select_mid, i_source_clock_select_lo};

    always_comb
    begin
        case (sel)
            SRC_4096HZ: sel_tick = tk.tick[0];
            SRC_64HZ: sel_tick = tk.tick[1];
            SRC_1HZ: sel_tick = tk.tick[2];
            SRC_MIN: sel_tick = tk.tick[3];
            SRC_HOUR: sel_tick = tk.tick[4];
            default: sel_tick = 1'b0;
        endcase
    end

    assign supply_ok = !i_supply_gating_enable
        || (i_backup_only_select ? i_on_backup : !i_on_backup);
    assign hold_eff = i_count_hold && !i_supply_gating_enable;
    assign halt_stop = i_clock_halt && (sel != SRC_4096HZ);
    assign advance = o_running && sel_tick && supply_ok && !hold_eff && !halt_stop;
    // event only on an advance from 0001h, which reloads the preset
    assign event_now = advance && (count == COUNT_ONE);

    // ====================================
    // Serial clock sampling
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ser_s1 <= 1'b0;
            ser_s2 <= 1'b0;
            ser_s3 <= 1'b0;
            ser_lvl <= 1'b0;
        end
        else
        begin
            ser_s1 <= i_ser_clk;
            ser_s2 <= ser_s1;
            ser_s3 <= ser_s2;
            if (ser_s2 == ser_s3)
            begin
                ser_lvl <= ser_s3;
            end
        end
    end

    assign ser_rise = (ser_s2 == ser_s3) && ser_s3 && !ser_lvl;

    // ====================================
    // Run control
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            run_prev <= 1'b0;
            start_pending <= 1'b0;
            o_running <= 1'b0;
        end
        else
        begin
            run_prev <= i_count_run;
            if (!i_count_run)
            begin
                start_pending <= 1'b0;
                o_running <= 1'b0;
            end
            else if (!run_prev)
            begin
                start_pending <= 1'b1;
            end
            else if (start_pending && ser_rise)
            begin
                start_pending <= 1'b0;
                o_running <= 1'b1;
            end
        end
    end

    // ====================================
    // Down counter
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            count <= COUNT_RST;
        end
        else if (start_pending && ser_rise && i_count_run && run_prev)
        begin
            count <= i_preset;
        end
        else if (event_now)
        begin
            count <= i_preset;
        end
        else if (advance && count != COUNT_RST)
        begin
            count <= count - COUNT_ONE;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_count <= COUNT_RST;
        end
        else
        begin
            o_count <= o_running ? count : i_preset;
        end
    end

    // ====================================
    // Event flag
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_timer_event_flag <= 1'b0;
        end
        else if (event_now)
        begin
            o_timer_event_flag <= 1'b1;
        end
        else if (i_flag_clear)
        begin
            o_timer_event_flag <= 1'b0;
        end
    end

    // ====================================
    // Interrupt pins
    // release time by source
    assign rel_limit = (sel == SRC_4096HZ) ? REL_W'(REL_FAST_CYCLES) : REL_W'(REL_SLOW_CYCLES);
    assign irq_active = o_int_out_a_oe || o_int_out_b_oe;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rel_cnt <= '0;
            o_int_out_a_oe <= 1'b0;
            o_int_out_b_oe <= 1'b0;
        end
        else if (!i_timer_irq_enable)
        begin
            rel_cnt <= '0;
            o_int_out_a_oe <= 1'b0;
            o_int_out_b_oe <= 1'b0;
        end
        else if (event_now)
        begin
            rel_cnt <= '0;
            o_int_out_a_oe <= i_irq_route_select;
            o_int_out_b_oe <= !i_irq_route_select;
        end
        else if (irq_active)
        begin
            if (rel_cnt >= rel_limit - REL_W'(1))
            begin
                rel_cnt <= '0;
                o_int_out_a_oe <= 1'b0;
                o_int_out_b_oe <= 1'b0;
            end
            else
            begin
                rel_cnt <= rel_cnt + REL_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_int_out_a <= 1'b0;
            o_int_out_b <= 1'b0;
        end
        else
        begin
            o_int_out_a <= 1'b0;
            o_int_out_b <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/fctim_monitor.sv
`default_nettype none
module fctim_monitor (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_count_run,
    input wire logic [fctim_pkg::COUNT_W-1:0] i_preset,
    input wire logic i_source_clock_select_hi,
    input wire logic i_source_clock_select_mid,
    input wire logic i_source_clock_select_lo,
    input wire logic i_timer_irq_enable,
    input wire logic i_supply_gating_enable,
    input wire logic i_backup_only_select,
    input wire logic i_on_backup,
    input wire logic i_count_hold,
    input wire logic i_clock_halt,
    input wire logic i_irq_route_select,
    input wire logic i_flag_clear,
    input wire logic o_timer_event_flag,
    input wire logic o_running,
    input wire logic [fctim_pkg::COUNT_W-1:0] o_count,
    input wire logic o_int_out_a,
    input wire logic o_int_out_a_oe,
    input wire logic o_int_out_b,
    input wire logic o_int_out_b_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import fctim_pkg::*;
    logic [2:0] src;
    assign src = {i_source_clock_select_hi, i_source_clock_select_mid, i_source_clock_select_lo};
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ========================================
    // Counting stalls
    sequence s_held(c);
        (o_running && i_count_run && c)[*3];
    endsequence
    a_hold_frozen:
        assert property (s_held(i_count_hold && !i_supply_gating_enable && !i_clock_halt)
            |=> $stable(o_count)) else $error("count moved while held");
    a_gate_frozen:
        assert property (s_held(i_supply_gating_enable && (i_backup_only_select != i_on_backup))
            |=> $stable(o_count)) else $error("count moved on wrong supply");
    a_halt_frozen:
        assert property (s_held((i_clock_halt && src != 3'h0) || src > 3'h4)
            |=> $stable(o_count)) else $error("count moved while halted");
    // ========================================
    // Interrupt pins, flag and run control
    a_pins_low_only:
        assert property (!o_int_out_a && !o_int_out_b) else $error("pin driven high");
    a_irq_off:
        assert property (!i_timer_irq_enable |=> !o_int_out_a_oe && !o_int_out_b_oe)
            else $error("pin low while disabled");
    a_route_a:
        assert property ($rose(o_int_out_a_oe) |-> $past(i_irq_route_select)
            && $past(i_timer_irq_enable)) else $error("pin a asserted wrongly");
    a_route_b:
        assert property ($rose(o_int_out_b_oe) |-> !$past(i_irq_route_select))
            else $error("pin b asserted wrongly");
    a_flag_sticky:
        assert property (o_timer_event_flag && !i_flag_clear |=> o_timer_event_flag)
            else $error("flag lost");
    a_run_low:
        assert property (!i_count_run |=> !o_running) else $error("running without run bit");
    a_start_preset:
        assert property ($rose(o_running) |=> o_count == $past(i_preset, 2))
            else $error("start not from preset");
endmodule
bind fctim_top fctim_monitor i_mon (.*);
`default_nettype wire

// >>> verif/fctim_host.sv
`default_nettype none
module fctim_host (
    output logic o_ser_clk,
    input wire logic i_oe_a,
    input wire logic i_oe_b,
    output wire logic o_irq_a_n,
    output wire logic o_irq_b_n
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_irq_a_n = i_oe_a ? 1'h0 : 1'h1;
    assign o_irq_b_n = i_oe_b ? 1'h0 : 1'h1;
    initial o_ser_clk = 1'h0;
    task automatic frame(input int k);
        #7;
        repeat (k)
        begin
            #160 o_ser_clk = 1'h1;
            #160 o_ser_clk = 1'h0;
        end
    endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fctim_pkg::*;
    localparam int TK = 4;
    localparam int RS = 20;
    logic i_clk, i_rst, ser_clk, run, en, gate, bko, onb, hold, halt, route, clr;
    logic flag, running, out_a, oe_a, out_b, oe_b;
    logic [2:0] src;
    logic [COUNT_W-1:0] preset, o_count, c0;
    wire logic irq_a_n, irq_b_n;
    int n_fail = 0, num_checks = 0, seed = 7, n, p;
    logic [7:0] cases [10] = '{8'h10, 8'h90, 8'hA0, 8'hE0, 8'hC0, 8'h20, 8'h09, 8'h08, 8'h05, 8'h01};
    fctim_top #(.TICK_CYCLES(TK), .REL_SLOW_CYCLES(RS)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_ser_clk(ser_clk), .i_count_run(run), .i_preset(preset),
        .i_source_clock_select_hi(src[2]), .i_source_clock_select_mid(src[1]),
        .i_source_clock_select_lo(src[0]), .i_timer_irq_enable(en),
        .i_supply_gating_enable(gate), .i_backup_only_select(bko), .i_on_backup(onb),
        .i_count_hold(hold), .i_clock_halt(halt), .i_irq_route_select(route),
        .i_flag_clear(clr), .o_timer_event_flag(flag), .o_running(running), .o_count(o_count),
        .o_int_out_a(out_a), .o_int_out_a_oe(oe_a), .o_int_out_b(out_b), .o_int_out_b_oe(oe_b));
    fctim_host host (.o_ser_clk(ser_clk), .i_oe_a(oe_a), .i_oe_b(oe_b),
        .o_irq_a_n(irq_a_n), .o_irq_b_n(irq_b_n));
    // ========================================
    // Model and tasks
    function automatic logic adv(input logic [7:0] s);
        logic g, b, o, h, t;
        logic [2:0] c;
        {g, b, o, h, t, c} = s;
        return (!g || b == o) && !(h && !g) && !(t && c != 3'h0) && c < 3'h5;
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clk);
    endtask
    task automatic stop_test();
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic start(input logic [15:0] v);
        run = 1'h0;
        preset = v;
        cyc(2);
        run = 1'h1;
        cyc(1);
        fork
            host.frame(8);
        join_none
        for (n = 0; n < 200 && running !== 1'h1; n++)
            cyc(1);
        chk("count_start", o_count, v);
    endtask
    task automatic next_event();
        clr = 1'h1;
        cyc(1);
        clr = 1'h0;
        for (n = 1; n < 3000 && flag !== 1'h1; n++)
            cyc(1);
    endtask
    // ========================================
    // Stimulus
    initial
    begin
        i_clk = 1'h0;
        forever #20 i_clk = ~i_clk;
    end
    initial
    begin
        cyc(20000);
        n_fail++;
        stop_test();
    end
    initial
    begin
        {run, en, gate, bko, onb, hold, halt, route, clr, src} = '0;
        preset = '0;
        i_rst = 1'h1;
        cyc(12);
        i_rst = 1'h0;
        chk("reset", {flag, running, oe_a, oe_b}, 4'h0);
        p = 2 + ($random(seed) & 7);
        en = 1'h1;
        route = 1'h1;
        start(p[15:0]);
        next_event();
        chk("irq_a", {irq_a_n, irq_b_n}, 2'h1);
        next_event();
        chk("interval", n, p * TK);
        chk("irq_kept", irq_a_n, 1'h0);
        en = 1'h0;
        cyc(2);
        chk("irq_off", irq_a_n, 1'h1);
        next_event();
        chk("no_irq", {irq_a_n, irq_b_n, flag}, 3'h7);
        route = 1'h0;
        en = 1'h1;
        next_event();
        chk("irq_b", {irq_a_n, irq_b_n}, 2'h2);
        run = 1'h0;
        cyc(3);
        chk("run_off", {running, irq_b_n}, 2'h0);
        clr = 1'h1;
        cyc(1);
        clr = 1'h0;
        chk("flag_clr", {flag, irq_b_n}, 2'h0);
        cyc(REL_FAST_CYCLES - 5);
        chk("rel_fast_hold", irq_b_n, 1'h0);
        cyc(1);
        chk("rel_fast", irq_b_n, 1'h1);
        en = 1'h0;
        for (int i = 0; i < 10; i++)
        begin
            {gate, bko, onb, hold, halt, src} = cases[i];
            start(16'h00C8);
            cyc(300);
            chk("moved", o_count !== 16'h00C8, adv(cases[i]));
            c0 = o_count;
            {gate, bko, onb, hold, halt, src} = '0;
            for (n = 0; n < 300 && o_count === c0; n++)
                cyc(1);
            chk("resume", o_count, c0 - 16'h0001);
        end
        hold = 1'h1;
        cyc(3);
        c0 = o_count;
        cyc(100);
        chk("held", o_count, c0);
        hold = 1'h0;
        for (n = 0; n < 300 && o_count === c0; n++)
            cyc(1);
        chk("resume_held", o_count, c0 - 16'h0001);
        en = 1'h1;
        route = 1'h1;
        src = 3'h1;
        start(16'h0001);
        next_event();
        cyc(RS - 1);
        chk("rel_slow_hold", irq_a_n, 1'h0);
        cyc(1);
        chk("rel_slow", irq_a_n, 1'h1);
        src = 3'h0;
        start(16'h0000);
        next_event();
        chk("zero_preset", {flag, irq_a_n, irq_b_n}, 3'h3);
        stop_test();
    end
endmodule
`default_nettype wire
